// >>> hdl/bcd_desc_source.sv
// Battery info and consumer port capability descriptor source with AXI4-Lite registers.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module bcd_desc_source
    import bcd_pkg::*;
#(
    parameter int NUM_BAT   = 7,
    parameter int NUM_PORTS = 16
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [15:0] power_source_bitmap,
    input  wire logic [15:0] sink_port_bitmap,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // -------------------------------------------------------------------------
    // Tables written by software, one entry per battery or per port
    // -------------------------------------------------------------------------
    logic [31:0] bat_str_reg   [NUM_BAT];
    logic [31:0] bat_full_reg  [NUM_BAT];
    logic [31:0] bat_min_reg   [NUM_BAT];
    logic [31:0] bat_des_reg   [NUM_BAT];
    logic [31:0] bat_last_reg  [NUM_BAT];

    logic [15:0] p_cap_reg     [NUM_PORTS];
    logic [31:0] p_volt_reg    [NUM_PORTS];
    logic [31:0] p_steady_reg  [NUM_PORTS];
    logic [31:0] p_burst_reg   [NUM_PORTS];
    logic [31:0] p_dur_reg     [NUM_PORTS];

    logic [1:0]  ctrl_reg;
    logic [31:0] sel_reg;

    logic [4:0]  rd_off_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;

    // -------------------------------------------------------------------------
    // Descriptor counts and port walk
    // -------------------------------------------------------------------------
    logic [2:0]  bat_count;
    logic [15:0] eff_ports;
    logic [4:0]  sink_count;
    logic [3:0]  sel_ord;
    logic [3:0]  port_of_ord;
    logic        sel_valid;
    logic        kind_sink;
    logic [4:0]  seen;

    // Battery count exists only when the battery source bit is set.
    assign bat_count = power_source_bitmap[BCD_PWR_SRC_BATTERY] ?
                       power_source_bitmap[13:11] : 3'h0;
    // A peripheral exposes only its upstream facing port; a hub exposes up to sixteen.
    assign eff_ports = ctrl_reg[BCD_CTRL_HUB] ? sink_port_bitmap
                     : {15'h0000, sink_port_bitmap[0]};

    assign sel_ord   = sel_reg[BCD_SEL_IDX +: 4];
    assign kind_sink = sel_reg[BCD_SEL_KIND];

    always_comb begin
        sink_count  = 5'h00;
        port_of_ord = 4'h0;
        seen        = 5'h00;
        // Ordinal n maps to the n-th set bit counted from port zero upward.
        // The search ripples over all ports: small, but a long path.
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (eff_ports[i]) begin
                if (seen == {1'b0, sel_ord}) begin
                    port_of_ord = 4'(i);
                end
                seen = seen + 5'h01;
            end
        end
        sink_count = seen;
    end

    // An ordinal past the last descriptor reads as zero bytes.
    assign sel_valid = kind_sink ? ({1'b0, sel_ord} < sink_count)
                                 : ({1'b0, sel_ord} < {2'b00, bat_count});

    // -------------------------------------------------------------------------
    // Descriptor byte generation
    // -------------------------------------------------------------------------
    logic [7:0]  desc_byte;
    logic [31:0] word_at;
    logic [2:0]  bi;
    logic [3:0]  pi;

    assign bi = sel_ord[2:0];
    assign pi = port_of_ord;

    always_comb begin
        word_at = 32'h0000_0000;

        if (kind_sink) begin
            unique case (rd_off_reg[4:2])
                3'h1: word_at = {p_volt_reg[pi][15:0], 13'h0000,
                                 p_cap_reg[pi][2:0] & BCD_PCAP_MASK};
                3'h2: word_at = {16'h0000, p_volt_reg[pi][31:16]};
                3'h3: word_at = p_steady_reg[pi];
                3'h4: word_at = p_burst_reg[pi];
                3'h5: word_at = ctrl_reg[BCD_CTRL_DUR_KNOWN] ? p_dur_reg[pi]
                              : BCD_DURATION_UNKNOWN;
                default: word_at = 32'h0000_0000;
            endcase
        end else begin
            unique case (rd_off_reg[4:2])
                3'h2: word_at = bat_full_reg[bi];
                3'h3: word_at = bat_min_reg[bi];
                3'h4: word_at = bat_des_reg[bi];
                3'h5: word_at = bat_last_reg[bi];
                default: word_at = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        desc_byte = 8'h00;
        // Fields are stored little endian so a byte walk returns the low byte first.
        desc_byte = word_at[8 * rd_off_reg[1:0] +: 8];

        // Header bytes and string indices bypass the word tables.
        unique case (rd_off_reg)
            BCD_OFF_LEN:  desc_byte = BCD_DESC_LEN;
            BCD_OFF_TYPE: desc_byte = BCD_DEVCAP_TYPE;
            BCD_OFF_CAP:  desc_byte = kind_sink ? BCD_CONSUMER_CAP_CODE
                                                : BCD_BATTERY_CAP_CODE;
            BCD_OFF_NAME: desc_byte = kind_sink ? 8'h00 : bat_str_reg[bi][7:0];
            BCD_OFF_SERIAL: if (!kind_sink) desc_byte = bat_str_reg[bi][15:8];
            BCD_OFF_MAKER:  if (!kind_sink) desc_byte = bat_str_reg[bi][23:16];
            BCD_OFF_ID:     if (!kind_sink) desc_byte = bat_str_reg[bi][31:24];
            5'h07:        desc_byte = kind_sink ? desc_byte : 8'h00;
            default: ;
        endcase

        if (!sel_valid || rd_off_reg >= BCD_DESC_LEN[4:0]) begin
            desc_byte = 8'h00;
        end
    end

    // -------------------------------------------------------------------------
    // AXI4-Lite write path
    // -------------------------------------------------------------------------
    logic do_write;
    logic w_hit;

    // A pending answer blocks both channels: one write in flight.
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr[7:0];
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end

            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    always_comb begin
        unique case (aw_addr_reg)
            BCD_A_CTRL, BCD_A_SEL, BCD_A_BAT_STR, BCD_A_BAT_FULL, BCD_A_BAT_MIN,
            BCD_A_BAT_DES, BCD_A_BAT_LAST, BCD_A_P_CAP, BCD_A_P_VOLT,
            BCD_A_P_STEADY, BCD_A_P_BURST, BCD_A_P_DUR: w_hit = 1'b1;
            default: w_hit = 1'b0;
        endcase
    end

    logic [2:0]  wb;
    logic [3:0]  wp;
    logic [31:0] tbl_old;
    logic [31:0] tbl_new;
    logic [31:0] ctrl_new;
    logic [31:0] sel_new;

    assign wb = sel_reg[BCD_SEL_IDX +: 3];
    assign wp = sel_reg[BCD_SEL_IDX +: 4];

    // Strobes keep unselected lanes, so the old word is fetched first.
    always_comb begin
        unique case (aw_addr_reg)
            BCD_A_BAT_STR:  tbl_old = bat_str_reg[wb];
            BCD_A_BAT_FULL: tbl_old = bat_full_reg[wb];
            BCD_A_BAT_MIN:  tbl_old = bat_min_reg[wb];
            BCD_A_BAT_DES:  tbl_old = bat_des_reg[wb];
            BCD_A_BAT_LAST: tbl_old = bat_last_reg[wb];
            BCD_A_P_CAP:    tbl_old = {16'h0000, p_cap_reg[wp]};
            BCD_A_P_VOLT:   tbl_old = p_volt_reg[wp];
            BCD_A_P_STEADY: tbl_old = p_steady_reg[wp];
            BCD_A_P_BURST:  tbl_old = p_burst_reg[wp];
            BCD_A_P_DUR:    tbl_old = p_dur_reg[wp];
            default:        tbl_old = 32'h0000_0000;
        endcase
    end

    assign tbl_new  = merge(tbl_old, w_data_reg, w_strb_reg);
    assign ctrl_new = merge({30'h0, ctrl_reg}, w_data_reg, w_strb_reg);
    assign sel_new  = merge(sel_reg, w_data_reg, w_strb_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= 2'h0;
            sel_reg  <= 32'h0000_0000;
        end else if (do_write) begin
            if (aw_addr_reg == BCD_A_CTRL) ctrl_reg <= ctrl_new[1:0];
            if (aw_addr_reg == BCD_A_SEL) sel_reg <= sel_new;
        end
    end

    // Table contents are configuration data; they have no reset so they map onto plain RAM.
    always_ff @(posedge aclk) begin
        if (do_write && wb < 3'(NUM_BAT)) begin
            unique case (aw_addr_reg)
                BCD_A_BAT_STR:  bat_str_reg[wb]  <= tbl_new;
                BCD_A_BAT_FULL: bat_full_reg[wb] <= tbl_new;
                BCD_A_BAT_MIN:  bat_min_reg[wb]  <= tbl_new;
                BCD_A_BAT_DES:  bat_des_reg[wb]  <= tbl_new;
                BCD_A_BAT_LAST: bat_last_reg[wb] <= tbl_new;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (do_write) begin
            unique case (aw_addr_reg)
                BCD_A_P_CAP:    p_cap_reg[wp]    <= tbl_new[15:0];
                BCD_A_P_VOLT:   p_volt_reg[wp]   <= tbl_new;
                BCD_A_P_STEADY: p_steady_reg[wp] <= tbl_new;
                BCD_A_P_BURST:  p_burst_reg[wp]  <= tbl_new;
                BCD_A_P_DUR:    p_dur_reg[wp]    <= tbl_new;
                default: ;
            endcase
        end
    end

    // The answer stands until the host takes it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= BCD_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_hit ? BCD_RESP_OKAY : BCD_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // AXI4-Lite read path and descriptor byte pointer
    // -------------------------------------------------------------------------
    logic        rd_take;
    logic [31:0] rd_word;
    logic        rd_hit;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take       = s_axi_arvalid && s_axi_arready;

    // Tables are write only; software sees them as descriptor bytes.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;

        unique case (s_axi_araddr[7:0])
            BCD_A_CTRL:   rd_word = {30'h0, ctrl_reg};
            BCD_A_SEL:    rd_word = sel_reg;
            BCD_A_DATA:   rd_word = {24'h000000, desc_byte};
            BCD_A_STATUS: rd_word = {8'h00, rd_off_reg, 3'h0, sink_count, 5'h00, bat_count,
                                     2'h0, sel_valid};
            default:      rd_hit  = 1'b0;
        endcase
    end

    // Read data is registered and stands until rready is seen.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= BCD_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? BCD_RESP_OKAY : BCD_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Each read of DATA advances one byte; a SEL write restarts the descriptor.
    // The pointer stops at the length, so over-reads return zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_off_reg <= 5'h00;
        end else if (do_write && aw_addr_reg == BCD_A_SEL) begin
            rd_off_reg <= 5'h00;
        end else if (rd_take && s_axi_araddr[7:0] == BCD_A_DATA
                     && rd_off_reg < BCD_DESC_LEN[4:0]) begin
            rd_off_reg <= rd_off_reg + 5'h01;
        end
    end
endmodule

// >>> hdl/bcd_pkg.sv
// Package with descriptor layout, register map and encodings for the capability descriptor source.
package bcd_pkg;
    // -------------------------------------------------------------------------
    // Descriptor layout
    // -------------------------------------------------------------------------
    localparam logic [7:0]  BCD_DESC_LEN         = 8'h18;
    localparam logic [7:0]  BCD_DEVCAP_TYPE      = 8'h10;
    localparam logic [7:0]  BCD_BATTERY_CAP_CODE = 8'h07;
    localparam logic [7:0]  BCD_CONSUMER_CAP_CODE = 8'h08;
    localparam logic [4:0]  BCD_OFF_LEN          = 5'h00;
    localparam logic [4:0]  BCD_OFF_TYPE         = 5'h01;
    localparam logic [4:0]  BCD_OFF_CAP          = 5'h02;
    localparam logic [4:0]  BCD_OFF_NAME         = 5'h03;
    localparam logic [4:0]  BCD_OFF_SERIAL       = 5'h04;
    localparam logic [4:0]  BCD_OFF_MAKER        = 5'h05;
    localparam logic [4:0]  BCD_OFF_ID           = 5'h06;
    localparam logic [4:0]  BCD_OFF_W8           = 5'h08;
    localparam logic [4:0]  BCD_OFF_W12          = 5'h0c;
    localparam logic [4:0]  BCD_OFF_W16          = 5'h10;
    localparam logic [4:0]  BCD_OFF_W20          = 5'h14;
    localparam logic [4:0]  BCD_OFF_PCAP         = 5'h04;
    localparam logic [4:0]  BCD_OFF_VMIN         = 5'h06;
    localparam logic [4:0]  BCD_OFF_VMAX         = 5'h08;
    localparam logic [4:0]  BCD_OFF_RSV10        = 5'h0a;
    localparam logic [2:0]  BCD_PCAP_MASK        = 3'h7;
    localparam logic [31:0] BCD_DURATION_UNKNOWN = 32'h0000ffff;
    localparam int          BCD_PWR_SRC_BATTERY  = 9;
    localparam logic [3:0]  BCD_PERIPH_MAX_SINK  = 4'h1;
    // -------------------------------------------------------------------------
    // Register map, byte addresses
    // -------------------------------------------------------------------------
    localparam logic [7:0] BCD_A_CTRL    = 8'h00;
    localparam logic [7:0] BCD_A_SEL     = 8'h04;
    localparam logic [7:0] BCD_A_DATA    = 8'h08;
    localparam logic [7:0] BCD_A_STATUS  = 8'h0c;
    localparam logic [7:0] BCD_A_BAT_STR = 8'h10;
    localparam logic [7:0] BCD_A_BAT_FULL = 8'h14;
    localparam logic [7:0] BCD_A_BAT_MIN = 8'h18;
    localparam logic [7:0] BCD_A_BAT_DES = 8'h1c;
    localparam logic [7:0] BCD_A_BAT_LAST = 8'h20;
    localparam logic [7:0] BCD_A_P_CAP   = 8'h24;
    localparam logic [7:0] BCD_A_P_VOLT  = 8'h28;
    localparam logic [7:0] BCD_A_P_STEADY = 8'h2c;
    localparam logic [7:0] BCD_A_P_BURST = 8'h30;
    localparam logic [7:0] BCD_A_P_DUR   = 8'h34;
    localparam logic [1:0] BCD_RESP_OKAY   = 2'h0;
    localparam logic [1:0] BCD_RESP_SLVERR = 2'h2;
    // SEL fields: bit 0 kind (0 battery, 1 consumer), bits 11:8 ordinal and write table slot.
    localparam int BCD_SEL_KIND = 0;
    localparam int BCD_SEL_IDX  = 8;
    localparam int BCD_CTRL_HUB = 0;
    localparam int BCD_CTRL_DUR_KNOWN = 1;
endpackage

// >>> verification/battery_consumer_cap_descriptors_tb.sv
// Self-checking bench for the capability descriptor source.
`timescale 1ns/1ns
module battery_consumer_cap_descriptors_tb
    import bcd_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn;
    logic [15:0] power_source_bitmap;
    logic [15:0] sink_port_bitmap;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  e [24];
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    always #20 aclk = ~aclk;
    bcd_desc_source uut (.aclk(aclk), .aresetn(aresetn),
        .power_source_bitmap(power_source_bitmap), .sink_port_bitmap(sink_port_bitmap),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    bcd_host_model host (.aclk(aclk), .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
        .awready(s_axi_awready), .wdata(s_axi_wdata), .wvalid(s_axi_wvalid),
        .wready(s_axi_wready), .bresp(s_axi_bresp), .bvalid(s_axi_bvalid),
        .bready(s_axi_bready), .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
        .arready(s_axi_arready), .rdata(s_axi_rdata), .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid), .rready(s_axi_rready));
    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            $display("[ERR] %0t run did not finish", $time);
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // Distinct bytes per entry and field, so a swapped or shifted byte shows up.
    function automatic logic [31:0] val(input int i, input int k);
        return {4'h0, i[3:0], 4'ha, k[3:0], 8'h5c, 4'h3, i[3:0]};
    endfunction
    function automatic logic [31:0] sel(input bit kind, input int n);
        return {20'h0, n[3:0], 7'h0, kind};
    endfunction
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        host.wr(a, d, r);
        chk({30'h0, r}, {30'h0, BCD_RESP_OKAY}, "write response");
    endtask
    task automatic put32(input int o, input logic [31:0] v);
        for (int i = 0; i < 4; i++) e[o + i] = v[8 * i +: 8];
    endtask
    task automatic hdr(input logic [7:0] code);
        e = '{default: 8'h00};
        e[0] = BCD_DESC_LEN;
        e[1] = BCD_DEVCAP_TYPE;
        e[2] = code;
    endtask
    task automatic exp_bat(input int b, input bit ok);
        hdr(BCD_BATTERY_CAP_CODE);
        put32(3, val(b, 0));
        for (int k = 1; k < 5; k++) put32(4 + 4 * k, val(b, k));
        if (!ok) e = '{default: 8'h00};
    endtask
    task automatic exp_port(input int p, input bit known, input bit ok);
        hdr(BCD_CONSUMER_CAP_CODE);
        put32(4, {29'h0, p[2:0]});
        put32(6, val(p, 1));
        put32(12, val(p, 2));
        put32(16, val(p, 3));
        put32(20, known ? val(p, 4) : BCD_DURATION_UNKNOWN);
        if (!ok) e = '{default: 8'h00};
    endtask
    // Reads one byte past the end as well, which must come back zero.
    task automatic chk_desc(input logic [31:0] s);
        logic [31:0] d;
        logic [1:0]  r;
        w(BCD_A_SEL, s);
        for (int i = 0; i < 25; i++) begin
            host.rd(BCD_A_DATA, d, r);
            chk({24'h0, d[7:0]}, (i < 24) ? {24'h0, e[i]} : 32'h0, "descriptor byte");
        end
    endtask
    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic t_battery();
        logic [31:0] d;
        logic [1:0]  r;
        power_source_bitmap <= 16'h1200;
        for (int b = 0; b < 2; b++) begin
            w(BCD_A_SEL, sel(1'b0, b));
            for (int k = 0; k < 5; k++) w(BCD_A_BAT_STR + 8'(4 * k), val(b, k));
        end
        host.rd(BCD_A_STATUS, d, r);
        chk({29'h0, d[5:3]}, 32'h2, "battery count");
        for (int b = 0; b < 3; b++) begin
            exp_bat(b, b < 2);
            chk_desc(sel(1'b0, b));
        end
        power_source_bitmap <= 16'h1000;
        exp_bat(0, 1'b0);
        chk_desc(sel(1'b0, 0));
    endtask
    task automatic t_consumer();
        int pl [3] = '{0, 3, 15};
        logic [31:0] d;
        logic [1:0]  r;
        sink_port_bitmap <= 16'h8009;
        w(BCD_A_CTRL, 32'h3);
        host.rd(BCD_A_STATUS, d, r);
        chk({27'h0, d[15:11]}, 32'h3, "consumer count");
        foreach (pl[j]) begin
            w(BCD_A_SEL, sel(1'b1, pl[j]));
            w(BCD_A_P_CAP, {29'h1fffffff, 3'(pl[j])});
            for (int k = 1; k < 5; k++) w(BCD_A_P_VOLT + 8'(4 * k - 4), val(pl[j], k));
        end
        for (int n = 0; n < 4; n++) begin
            exp_port((n < 3) ? pl[n] : 0, 1'b1, n < 3);
            chk_desc(sel(1'b1, n));
        end
        w(BCD_A_CTRL, 32'h1);
        exp_port(3, 1'b0, 1'b1);
        chk_desc(sel(1'b1, 1));
        w(BCD_A_CTRL, 32'h0);
        exp_port(0, 1'b0, 1'b1);
        chk_desc(sel(1'b1, 0));
        exp_port(0, 1'b0, 1'b0);
        chk_desc(sel(1'b1, 1));
    endtask
    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0]  r;
        host.wr(8'h38, 32'hffffffff, r);
        chk({30'h0, r}, {30'h0, BCD_RESP_SLVERR}, "unmapped write response");
        host.rd(8'h38, d, r);
        chk({30'h0, r}, {30'h0, BCD_RESP_SLVERR}, "unmapped read response");
    endtask
    initial begin
        aresetn = 1'b0;
        power_source_bitmap = 16'h0;
        sink_port_bitmap = 16'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_battery();
        t_consumer();
        t_unmapped();
        end_sim();
    end
endmodule

// >>> verification/bcd_desc_monitor.sv
// Protocol checker bound to the descriptor source register port.
`timescale 1ns/1ns
module bcd_desc_monitor
    import bcd_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence aw_take; s_axi_awvalid && s_axi_awready; endsequence
    sequence w_take; s_axi_wvalid && s_axi_wready; endsequence
    sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
    reset_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
        else $error("response pending after reset");
    rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    wr_answer_a: assert property ((aw_take and w_take) |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    rd_err_a: assert property (ar_take ##0 s_axi_araddr[7:0] > BCD_A_P_DUR
        |=> s_axi_rresp == BCD_RESP_SLVERR)
        else $error("unmapped read not refused");
    rd_ok_a: assert property (ar_take ##0 s_axi_araddr[7:0] == BCD_A_DATA
        |=> s_axi_rresp == BCD_RESP_OKAY)
        else $error("descriptor read refused");
endmodule
bind bcd_desc_source bcd_desc_monitor mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> verification/bcd_host_model.sv
// Host-side register master that loads and reads the descriptor tables.
`timescale 1ns/1ns
module bcd_host_model (
    input  wire logic        aclk,
    output logic [31:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [31:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awaddr, wdata, araddr} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
    end
    // Released payloads are inverted so a slave sampling late sees garbage.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_d;
        logic w_d;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_d = 1'b0;
        w_d = 1'b0;
        while (!(aw_d && w_d)) begin
            @(posedge aclk);
            if (!aw_d && awready) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (!w_d && wready) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
        end
        while (!bvalid) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~araddr;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule
